// >>> include/sleep_gate_pkg.sv
package sleep_gate_pkg;

	localparam logic [11:0] SLEEP_GATES_ONE_ADDR = 12'h114;
	localparam logic [11:0] RUN_CFG_ADDR = 12'h060;
	localparam logic [11:0] POWER_MODE_ADDR = 12'h200;
	localparam logic [11:0] FAULT_STATUS_ADDR = 12'h204;
	localparam logic [11:0] FAULT_MASK_ADDR = 12'h208;

	// Implemented bits of the gate register
	localparam logic [31:0] GATE_WRITE_MASK = 32'h070F_1013;
	localparam logic [31:0] GATE_RESET = 32'h0000_0000;

	localparam int COMPARATOR_ZERO_BIT = 24;
	localparam int TIMER_ZERO_BIT = 16;
	localparam int TWO_WIRE_ZERO_BIT = 12;
	localparam int SYNC_SERIAL_ZERO_BIT = 4;
	localparam int ASYNC_SERIAL_ZERO_BIT = 0;

	localparam int AUTO_GATE_BIT = 27;
	localparam int NUM_PERIPH = 11;
	localparam int PERIPH_SEL_W = 4;

	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_SLEEP = 2'b01,
		MODE_DEEP_SLEEP = 2'b10
	} power_mode_t;

endpackage

// >>> logic/bus_fault_check.sv
module bus_fault_check
	import sleep_gate_pkg::*;
(
	input wire logic [NUM_PERIPH-1:0] clock_on_i,
	input wire logic access_i,
	input wire logic [PERIPH_SEL_W-1:0] target_i,
	output logic fault_o
);

	always_comb begin
		fault_o = 1'b0;
		if (access_i && (target_i < PERIPH_SEL_W'(NUM_PERIPH))) begin
			fault_o = !clock_on_i[target_i];
		end
	end

endmodule // bus_fault_check

// >>> logic/sleep_clock_gate_bank_one.sv
// Behaviour
// - Each implemented bit enables one peripheral clock
// - Access to unclocked peripheral raises bus fault
// - All gate bits reset to zero
// - Gates apply only during sleep operation
// - Only effective when auto gating bit set
// - Bits 26..24 gate comparators two..zero
// - Reserved bits read zero, software preserves
// - Bits 19..16 gate timers three..zero
// - Bit 12 gates two-wire module zero
// - Bit 4 gates sync serial zero
// - Bits 1..0 gate async serial one..zero
//
// Local design decision: the APB slave port.
module sleep_clock_gate_bank_one
	import sleep_gate_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic PERIPH_ACCESS_I,
	input wire logic [PERIPH_SEL_W-1:0] PERIPH_TARGET_I,
	output logic PERIPH_BUS_FAULT_O,
	output logic [NUM_PERIPH-1:0] PERIPH_CLK_EN_O,
	output logic IRQ_O
);

////////////////////////////////////////////////////////////////////////
	// Register state
	logic [31:0] gates_q;
	logic auto_gate_q;
	power_mode_t mode_q;
	logic fault_sts_q;
	logic fault_mask_q;

	// Gating path
	logic sleep_gating;
	logic [NUM_PERIPH-1:0] gate_vec;
	logic [NUM_PERIPH-1:0] clk_on;
	logic [NUM_PERIPH-1:0] clk_en_q;

	// Fault path
	logic fault_now;
	logic fault_q;
	logic fault_set;
	logic fault_clr;
	logic irq_d;
	logic irq_q;

	// Bus strobes
	logic setup;
	logic wr;
	logic rd;
	logic hit;

	// Register selects
	logic sel_gates;
	logic sel_run_cfg;
	logic sel_mode;
	logic sel_status;
	logic sel_mask;
	logic wr_gates;
	logic wr_run_cfg;
	logic wr_mode;
	logic wr_mask;
	logic rd_status;

	// Data paths
	logic mode_code_ok;
	logic [31:0] wdata_gates;
	logic [31:0] gates_rd;
	logic [1:0] mode_bits;
	logic [31:0] rdata_d;
	logic [31:0] prdata_d;
	logic [31:0] prdata_q;
	logic pslverr_d;
	logic pslverr_q;
	logic pready_q;

	// Gate bit of each peripheral index
	localparam int GATE_POS [NUM_PERIPH] = '{
		ASYNC_SERIAL_ZERO_BIT,
		ASYNC_SERIAL_ZERO_BIT + 1,
		SYNC_SERIAL_ZERO_BIT,
		TWO_WIRE_ZERO_BIT,
		TIMER_ZERO_BIT,
		TIMER_ZERO_BIT + 1,
		TIMER_ZERO_BIT + 2,
		TIMER_ZERO_BIT + 3,
		COMPARATOR_ZERO_BIT,
		COMPARATOR_ZERO_BIT + 1,
		COMPARATOR_ZERO_BIT + 2
	};

////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign setup = PSEL_I && !PENABLE_I;
	assign wr = pready_q && PWRITE_I;
	assign rd = pready_q && !PWRITE_I;

	// One select per mapped word
	always_comb begin
		sel_gates = 1'b0;
		sel_run_cfg = 1'b0;
		sel_mode = 1'b0;
		sel_status = 1'b0;
		sel_mask = 1'b0;
		unique case (PADDR_I)
			SLEEP_GATES_ONE_ADDR: sel_gates = 1'b1;
			RUN_CFG_ADDR: sel_run_cfg = 1'b1;
			POWER_MODE_ADDR: sel_mode = 1'b1;
			FAULT_STATUS_ADDR: sel_status = 1'b1;
			FAULT_MASK_ADDR: sel_mask = 1'b1;
			default: sel_gates = 1'b0;
		endcase
	end

	assign hit = sel_gates || sel_run_cfg || sel_mode
		|| sel_status || sel_mask;

	// Strobes that land at the edge ending the access
	assign wr_gates = wr && sel_gates;
	assign wr_run_cfg = wr && sel_run_cfg;
	assign wr_mode = wr && sel_mode;
	assign wr_mask = wr && sel_mask;
	assign rd_status = rd && sel_status;

	// Code three of the mode field names no mode; such writes are dropped
	assign mode_code_ok = (PWDATA_I[1:0] == MODE_RUN)
		|| (PWDATA_I[1:0] == MODE_SLEEP)
		|| (PWDATA_I[1:0] == MODE_DEEP_SLEEP);

	// Reserved positions never take write data and always read zero
	assign wdata_gates = PWDATA_I & GATE_WRITE_MASK;
	assign gates_rd = gates_q & GATE_WRITE_MASK;
	assign mode_bits = mode_q;

////////////////////////////////////////////////////////////////////////
	// Access phase lasts exactly one wait-free cycle after setup
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setup;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (PADDR_I)
			SLEEP_GATES_ONE_ADDR: begin
				rdata_d = gates_rd;
			end
			RUN_CFG_ADDR: begin
				rdata_d[AUTO_GATE_BIT] = auto_gate_q;
			end
			POWER_MODE_ADDR: begin
				rdata_d[1:0] = mode_bits;
			end
			FAULT_STATUS_ADDR: begin
				rdata_d[0] = fault_sts_q;
			end
			FAULT_MASK_ADDR: begin
				rdata_d[0] = fault_mask_q;
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// Read data stands only while ready is high
	always_comb begin
		prdata_d = 32'h0000_0000;
		pslverr_d = 1'b0;
		if (setup) begin
			prdata_d = rdata_d;
			pslverr_d = !hit;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			prdata_q <= 32'h0000_0000;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	// Error flag pulses with ready
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= pslverr_d;
		end
	end

////////////////////////////////////////////////////////////////////////
	// Gate register
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			gates_q <= GATE_RESET;
		end else begin
			if (wr_gates) begin
				gates_q <= wdata_gates;
			end
		end
	end

	// Auto gating bit of the run configuration word
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			auto_gate_q <= 1'b0;
		end else begin
			if (wr_run_cfg) begin
				auto_gate_q <= PWDATA_I[AUTO_GATE_BIT];
			end
		end
	end

	// Power mode; an unknown code leaves the mode as it was
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			mode_q <= MODE_RUN;
		end else begin
			if (wr_mode && mode_code_ok) begin
				mode_q <= power_mode_t'(PWDATA_I[1:0]);
			end
		end
	end

	// Fault interrupt mask
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			fault_mask_q <= 1'b0;
		end else begin
			if (wr_mask) begin
				fault_mask_q <= PWDATA_I[0];
			end
		end
	end

////////////////////////////////////////////////////////////////////////
	// Sleep bank governs only in sleep with auto gating on
	assign sleep_gating = (mode_q == MODE_SLEEP)
		&& auto_gate_q;

	// Outside that state clocks stay on; other banks are not built here
	genvar g;
	generate
		for (g = 0; g < NUM_PERIPH; g++) begin : gen_gate
			assign gate_vec[g] = gates_q[GATE_POS[g]];
			assign clk_on[g] = sleep_gating ? gate_vec[g] : 1'b1;
		end
	endgenerate

	// Enables leave through a register
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			clk_en_q <= '0;
		end else begin
			clk_en_q <= clk_on;
		end
	end

////////////////////////////////////////////////////////////////////////
	// Fault decode against the registered enables
	bus_fault_check u_fault (
		.clock_on_i(clk_en_q),
		.access_i(PERIPH_ACCESS_I),
		.target_i(PERIPH_TARGET_I),
		.fault_o(fault_now)
	);

	// Fault pulse one cycle after the access
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= fault_now;
		end
	end

	assign fault_set = fault_now;
	assign fault_clr = rd_status;

	// Set wins over read-clear
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			fault_sts_q <= 1'b0;
		end else begin
			if (fault_set) begin
				fault_sts_q <= 1'b1;
			end else if (fault_clr) begin
				fault_sts_q <= 1'b0;
			end
		end
	end

	// Level stays up while an unmasked status bit is set
	always_comb begin
		irq_d = 1'b0;
		if (fault_mask_q) begin
			if (fault_set) begin
				irq_d = 1'b1;
			end else if (fault_sts_q && !fault_clr) begin
				irq_d = 1'b1;
			end
		end
	end

	// Registered so the pin comes straight from a flop
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

////////////////////////////////////////////////////////////////////////
	// Bus answer
	assign PRDATA_O = prdata_q;
	assign PREADY_O = pready_q;
	assign PSLVERR_O = pslverr_q;

	// Peripheral side
	assign PERIPH_BUS_FAULT_O = fault_q;
	assign PERIPH_CLK_EN_O = clk_en_q;
	assign IRQ_O = irq_q;

endmodule // sleep_clock_gate_bank_one

// >>> verification/gate_properties.sv
module gate_chk
	import sleep_gate_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PERIPH_ACCESS_I,
	input wire logic [PERIPH_SEL_W-1:0] PERIPH_TARGET_I,
	input wire logic PERIPH_BUS_FAULT_O,
	input wire logic [NUM_PERIPH-1:0] PERIPH_CLK_EN_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	property p_rdy; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_one; PREADY_O |=> !PREADY_O; endproperty
	a_one: assert property (p_one) else $error("long ready");
	property p_res; PREADY_O && !PWRITE_I && PADDR_I == SLEEP_GATES_ONE_ADDR
		|-> (PRDATA_O & ~GATE_WRITE_MASK) == 0; endproperty
	a_res: assert property (p_res) else $error("reserved set");
	property p_flt; PERIPH_ACCESS_I && PERIPH_TARGET_I < NUM_PERIPH &&
		!PERIPH_CLK_EN_O[PERIPH_TARGET_I] |=> PERIPH_BUS_FAULT_O; endproperty
	a_flt: assert property (p_flt) else $error("no fault");
	property p_nof; !PERIPH_ACCESS_I |=> !PERIPH_BUS_FAULT_O; endproperty
	a_nof: assert property (p_nof) else $error("stray fault");
	property p_on; PERIPH_ACCESS_I && PERIPH_CLK_EN_O[PERIPH_TARGET_I]
		|=> !PERIPH_BUS_FAULT_O; endproperty
	a_on: assert property (p_on) else $error("fault when on");
	property p_rst; $fell(RST_I) |-> PERIPH_CLK_EN_O == 0; endproperty
	a_rst: assert property (p_rst) else $error("reset enables");
	property p_chg; !$stable(PERIPH_CLK_EN_O) && !$past(RST_I, 2)
		|-> $past(PREADY_O, 2) && $past(PWRITE_I, 2); endproperty
	a_chg: assert property (p_chg) else $error("enable moved");
endmodule // gate_chk

bind sleep_clock_gate_bank_one gate_chk chk_u (.CORE_CLK_I, .RST_I,
	.PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O, .PREADY_O,
	.PERIPH_ACCESS_I, .PERIPH_TARGET_I, .PERIPH_BUS_FAULT_O,
	.PERIPH_CLK_EN_O);

// >>> verification/tb_sleep_clock_gate_bank_one.sv
module tb_sleep_clock_gate_bank_one
	import sleep_gate_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic c = 0, r = 1, ps = 0, pe = 0, pw = 0, ac = 0;
	logic [11:0] pa = '0;
	logic [31:0] pd = '0, rd, prd;
	logic [3:0] tg = '0;
	logic rdy, er, sle, flt, irq;
	logic [10:0] en;
	int bad_count = 0, tests_run = 0;
	int pos[11] = '{0, 1, 4, 12, 16, 17, 18, 19, 24, 25, 26};
	initial forever #10 c = ~c;
	sleep_clock_gate_bank_one dut_u (.CORE_CLK_I(c), .RST_I(r), .PSEL_I(ps),
		.PENABLE_I(pe), .PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(pd),
		.PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(sle),
		.PERIPH_ACCESS_I(ac), .PERIPH_TARGET_I(tg),
		.PERIPH_BUS_FAULT_O(flt), .PERIPH_CLK_EN_O(en), .IRQ_O(irq));
	task complete_run;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge c);
		ps <= 1;
		pw <= w;
		pa <= a;
		pd <= d;
		n = 0;
		@(posedge c);
		pe <= 1;
		do begin
			@(posedge c);
			n++;
		end while (rdy !== 1 && n < 20);
		rd = prd;
		er = sle;
		ps <= 0;
		pe <= 0;
		if (n >= 20) begin
			bad_count++;
			complete_run;
		end
	endtask
	task acc(input logic [3:0] t, input logic e);
		@(posedge c);
		ac <= 1;
		tg <= t;
		@(posedge c);
		ac <= 0;
		#1 chk(flt, e);
	endtask
	initial begin
		repeat (5) @(posedge c);
		r <= 0;
		apb(0, SLEEP_GATES_ONE_ADDR, 0);
		chk(rd, GATE_RESET);
		chk(en, 11'h7FF);
		apb(1, SLEEP_GATES_ONE_ADDR, 32'hFFFF_FFFF);
		apb(0, SLEEP_GATES_ONE_ADDR, 0);
		chk(rd, 32'h070F_1013);
		apb(0, 12'h0FC, 0);
		chk(er, 1);
		apb(1, POWER_MODE_ADDR, 1);
		acc(4'h5, 0);
		apb(1, RUN_CFG_ADDR, 32'h0800_0000);
		for (int i = 0; i < 11; i++) begin
			apb(1, SLEEP_GATES_ONE_ADDR, 32'h1 << pos[i]);
			acc(4'(i), 0);
			acc(4'((i + 1) % 11), 1);
			chk(en, 11'h1 << i);
		end
		apb(1, FAULT_MASK_ADDR, 1);
		apb(0, FAULT_STATUS_ADDR, 0);
		acc(4'h0, 1);
		chk(irq, 1);
		apb(0, FAULT_STATUS_ADDR, 0);
		chk(rd, 1);
		@(posedge c);
		#1 chk(irq, 0);
		apb(1, FAULT_MASK_ADDR, 0);
		acc(4'h1, 1);
		chk(irq, 0);
		apb(1, POWER_MODE_ADDR, 2);
		repeat (2) @(posedge c);
		#1 chk(en, 11'h7FF);
		complete_run;
	end
endmodule // tb_sleep_clock_gate_bank_one
